// >>> logic/quad_pot_i2c_wiper_control.sv
// Two-wire bus slave and wiper control logic for a four-channel potentiometer.
`timescale 1ns/1ps
`include "pot_defs.svh"

// Contract
// - Each of four channels keeps its own 6-bit wiper position register.
// - Each channel offers 64 taps selected by its wiper position value.
// - Each channel owns four 6-bit stored settings in non-volatile storage.
// - After reset, each channel's first stored setting is copied to its wiper.
// - Stored settings are written only by bus transactions from master; wipers also by the recall after reset.
// - Guard low refuses stored-setting writes but still allows wiper writes.
// - Guard high permits every read and write including stored programming.
// - Four address pins form the low slave address bits, bit0 least significant.
// - A transaction starts only when the sent address matches the pins.
// - The data line is only pulled low or released, never driven high.
// - All transfers are timed by the master's serial clock.
// - Instructions move data between a wiper and its own stored settings.
// - Exactly one tap per channel is selected, by the wiper position.
module quad_pot_i2c_wiper_control #(
	parameter int         CHANNELS = 4,
	parameter int         TAPS     = 64,
	parameter int         PW       = 6,
	parameter logic [5:0] NV_INIT  = `POT_NV_INIT
) (
	input  wire logic                          sys_clk_i,
	input  wire logic                          rst_i,
	input  wire logic                          scl_i,
	input  wire logic                          sda_i,
	output logic                               sda_o,
	output logic                               sda_oe_n_o,
	input  wire logic                          addr_pin_bit0_i,
	input  wire logic                          addr_pin_bit1_i,
	input  wire logic                          addr_pin_bit2_i,
	input  wire logic                          addr_pin_bit3_i,
	input  wire logic                          write_guard_n_i,
	output logic [CHANNELS-1:0][PW-1:0]        wiper_position_o,
	output logic [CHANNELS-1:0][TAPS-1:0]      tap_sel_o
);
	import pot_pkg::*;

	pot_state_e       state_q;
	pot_state_e       next_q;
	pot_state_e       nxt;
	logic             scl_q;
	logic             sda_q;
	logic             scl_rise;
	logic             scl_fall;
	logic             start_det;
	logic             stop_det;
	logic             byte_done;
	logic             accept;
	logic             drv_q;
	logic             exec_q;
	logic             exec_now;
	logic [3:0]       cnt_q;
	logic [7:0]       sh_q;
	logic [7:0]       tx_src;
	logic [2:0]       ld_q;
	logic [3:0]       my_addr;
	logic [3:0]       rd_addr;
	logic [PW-1:0]    rd_data;
	instr_s           instr_q;
	instr_s           instr_in;
	nv_wr_s           nv_wr;
	logic             wip_we;
	logic [1:0]       wip_ch;
	logic [PW-1:0]    wip_data;
	logic [PW-1:0]    wiper_q [CHANNELS];

	// Stored-setting address is channel times four plus slot.
	function automatic logic [3:0] nv_index(input logic [1:0] ch, input logic [1:0] slot);
		nv_index = {ch, slot};
	endfunction : nv_index

	assign my_addr = {addr_pin_bit3_i, addr_pin_bit2_i,
		addr_pin_bit1_i, addr_pin_bit0_i};
	assign instr_in = instr_s'(sh_q);

	// Inputs are synchronous, so one register is enough to see bus edges.
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl_i;
			sda_q <= sda_i;
		end
	end

	always_comb begin
		scl_rise  = scl_i & ~scl_q;
		scl_fall  = ~scl_i & scl_q;
		start_det = scl_i & scl_q & sda_q & ~sda_i;
		stop_det  = scl_i & scl_q & ~sda_q & sda_i;
		byte_done = scl_fall && (cnt_q == `POT_BYTE_BITS);
		exec_now  = (state_q == ST_ACK) && scl_fall && exec_q;
	end

	// Decide the acknowledge and the follow-on phase of each received byte.
	always_comb begin
		accept = 1'b0;
		nxt    = ST_IGNORE;
		case (state_q)
			ST_ADDR: begin
				accept = (sh_q[7:1] == {`POT_ADDR_PREFIX, my_addr}) && !sh_q[0];
				nxt    = ST_INSTR;
			end
			ST_INSTR: begin
				case (instr_in.op)
					`POT_OP_RD_WIPER, `POT_OP_RD_NV: begin
						accept = 1'b1;
						nxt    = ST_TX;
					end
					`POT_OP_WR_WIPER, `POT_OP_WR_NV: begin
						accept = 1'b1;
						nxt    = ST_DATA;
					end
					`POT_OP_NV_TO_WIP: begin
						accept = 1'b1;
					end
					`POT_OP_WIP_TO_NV: begin
						accept = write_guard_n_i;
					end
					default: begin
						accept = 1'b0;
					end
				endcase
			end
			ST_DATA: begin
				accept = (instr_q.op == `POT_OP_WR_WIPER) || write_guard_n_i;
			end
			default: begin
				accept = 1'b0;
			end
		endcase
	end

	assign tx_src = {2'h0, (instr_q.op == `POT_OP_RD_WIPER) ? wiper_q[instr_q.ch] : rd_data};

	// Bus protocol sequencer.
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_q <= ST_LOAD;
			next_q  <= ST_IGNORE;
			cnt_q   <= 4'h0;
			sh_q    <= 8'h00;
			drv_q   <= 1'b0;
			exec_q  <= 1'b0;
			instr_q <= '0;
		end else if (state_q == ST_LOAD) begin
			if (ld_q == `POT_LOAD_DONE) begin
				state_q <= ST_IDLE;
			end
		end else if (start_det) begin
			state_q <= ST_ADDR;
			cnt_q   <= 4'h0;
			drv_q   <= 1'b0;
			exec_q  <= 1'b0;
		end else if (stop_det) begin
			state_q <= ST_IDLE;
			drv_q   <= 1'b0;
			exec_q  <= 1'b0;
		end else begin
			case (state_q)
				ST_ADDR, ST_INSTR, ST_DATA: begin
					if (scl_rise) begin
						sh_q  <= {sh_q[6:0], sda_i};
						cnt_q <= cnt_q + 4'h1;
					end
					if (byte_done) begin
						cnt_q   <= 4'h0;
						state_q <= ST_ACK;
						drv_q   <= accept;
						next_q  <= accept ? nxt : ST_IGNORE;
						if (state_q == ST_INSTR) begin
							instr_q <= instr_in;
							exec_q  <= accept && (nxt == ST_IGNORE);
						end
					end
				end
				ST_ACK: begin
					if (scl_fall) begin
						state_q <= next_q;
						exec_q  <= 1'b0;
						drv_q   <= (next_q == ST_TX) ? ~tx_src[7] : 1'b0;
						if (next_q == ST_TX) begin
							sh_q <= tx_src;
						end
					end
				end
				ST_TX: begin
					if (scl_fall) begin
						if (cnt_q == `POT_LAST_TX_BIT) begin
							state_q <= ST_MACK;
							drv_q   <= 1'b0;
							cnt_q   <= 4'h0;
						end else begin
							sh_q  <= {sh_q[6:0], 1'b0};
							drv_q <= ~sh_q[6];
							cnt_q <= cnt_q + 4'h1;
						end
					end
				end
				ST_MACK: begin
					if (scl_rise) begin
						// A master acknowledge asks for the same setting again.
						state_q <= sda_i ? ST_IGNORE : ST_ACK;
						next_q  <= ST_TX;
					end
				end
				ST_IDLE, ST_IGNORE: begin
					drv_q <= 1'b0;
				end
				default: begin
					state_q <= ST_IDLE;
					drv_q   <= 1'b0;
				end
			endcase
		end
	end

	// Open drain: the pad value is always low, only the enable moves.
	assign sda_o      = 1'b0;
	assign sda_oe_n_o = ~drv_q;

	// Power-up recall walks the four channels one per cycle.
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			ld_q <= 3'h0;
		end else if (state_q == ST_LOAD && ld_q != `POT_LOAD_DONE) begin
			ld_q <= ld_q + 3'h1;
		end
	end

	always_comb begin
		if (state_q == ST_LOAD) begin
			rd_addr = nv_index(ld_q[1:0], `POT_FIRST_SLOT);
		end else begin
			rd_addr = nv_index(instr_q.ch, instr_q.slot);
		end
	end

	// Wiper writers: recall, bus write, and stored-to-wiper transfer.
	always_comb begin
		wip_we   = 1'b0;
		wip_ch   = instr_q.ch;
		wip_data = sh_q[PW-1:0];
		if (state_q == ST_LOAD && ld_q != 3'h0) begin
			wip_we   = 1'b1;
			wip_ch   = 2'(ld_q - 3'h1);
			wip_data = rd_data;
		end else if (state_q == ST_DATA && byte_done && !start_det && !stop_det
				&& instr_q.op == `POT_OP_WR_WIPER) begin
			wip_we = 1'b1;
		end else if (exec_now && instr_q.op == `POT_OP_NV_TO_WIP) begin
			wip_we   = 1'b1;
			wip_data = rd_data;
		end
	end

	// Stored-setting writers, both gated by the write guard.
	always_comb begin
		nv_wr.en   = 1'b0;
		nv_wr.addr = nv_index(instr_q.ch, instr_q.slot);
		nv_wr.data = sh_q[PW-1:0];
		if (state_q == ST_DATA && byte_done && !start_det && !stop_det
				&& instr_q.op == `POT_OP_WR_NV) begin
			nv_wr.en = write_guard_n_i;
		end else if (exec_now && instr_q.op == `POT_OP_WIP_TO_NV) begin
			nv_wr.en   = write_guard_n_i;
			nv_wr.data = wiper_q[instr_q.ch];
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			for (int i = 0; i < CHANNELS; i++) begin
				wiper_q[i] <= `POT_WIPER_RESET;
			end
		end else if (wip_we) begin
			wiper_q[wip_ch] <= wip_data;
		end
	end

	nv_store #(
		.WIDTH (PW),
		.DEPTH (CHANNELS * 4),
		.AW    (4),
		.INIT  (NV_INIT)
	) u_nv (
		.sys_clk_i (sys_clk_i),
		.rst_i     (rst_i),
		.wr_i      (nv_wr),
		.rd_addr_i (rd_addr),
		.rd_data_o (rd_data)
	);

	genvar g;
	generate
		for (g = 0; g < CHANNELS; g++) begin : g_chan
			assign wiper_position_o[g] = wiper_q[g];
			tap_decode #(
				.TAPS (TAPS),
				.PW   (PW)
			) u_tap (
				.pos_i     (wiper_q[g]),
				.tap_sel_o (tap_sel_o[g])
			);
		end
	endgenerate

endmodule : quad_pot_i2c_wiper_control

// >>> logic/pot_defs.svh
// Offsets, encodings, reset values and counts for the quad wiper controller.
`ifndef POT_DEFS_SVH
`define POT_DEFS_SVH

`define POT_ADDR_PREFIX   3'h2
`define POT_OP_RD_WIPER   4'h9
`define POT_OP_WR_WIPER   4'ha
`define POT_OP_RD_NV      4'hb
`define POT_OP_WR_NV      4'hc
`define POT_OP_NV_TO_WIP  4'hd
`define POT_OP_WIP_TO_NV  4'he
`define POT_BYTE_BITS     4'h8
`define POT_LAST_TX_BIT   4'h7
`define POT_LOAD_DONE     3'h4
`define POT_WIPER_RESET   6'h00
`define POT_NV_INIT       6'h20
`define POT_FIRST_SLOT    2'h0

`endif

// >>> logic/pot_pkg.sv
// Types shared by the quad wiper controller files.
package pot_pkg;

	typedef enum logic [3:0] {
		ST_LOAD,
		ST_IDLE,
		ST_ADDR,
		ST_INSTR,
		ST_DATA,
		ST_ACK,
		ST_TX,
		ST_MACK,
		ST_IGNORE
	} pot_state_e;

	typedef struct packed {
		logic [3:0] op;
		logic [1:0] slot;
		logic [1:0] ch;
	} instr_s;

	typedef struct packed {
		logic       en;
		logic [3:0] addr;
		logic [5:0] data;
	} nv_wr_s;

endpackage : pot_pkg

// >>> logic/nv_store.sv
// Small memory holding the stored wiper settings, registered read data.
`timescale 1ns/1ps
`include "pot_defs.svh"

module nv_store #(
	parameter int         WIDTH = 6,
	parameter int         DEPTH = 16,
	parameter int         AW    = 4,
	parameter logic [5:0] INIT  = `POT_NV_INIT
) (
	input  wire logic              sys_clk_i,
	input  wire logic              rst_i,
	input  wire pot_pkg::nv_wr_s   wr_i,
	input  wire logic [AW-1:0]     rd_addr_i,
	output logic      [WIDTH-1:0]  rd_data_o
);
	import pot_pkg::*;

	// The array has no reset because its contents must survive a reset.
	logic [WIDTH-1:0] mem_q [DEPTH] = '{default: WIDTH'(INIT)};

	always_ff @(posedge sys_clk_i) begin
		if (wr_i.en) begin
			mem_q[wr_i.addr[AW-1:0]] <= wr_i.data[WIDTH-1:0];
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rd_data_o <= '0;
		end else begin
			rd_data_o <= mem_q[rd_addr_i];
		end
	end

endmodule : nv_store

// >>> logic/tap_decode.sv
// One-hot tap select decoder for one potentiometer channel.
`timescale 1ns/1ps

module tap_decode #(
	parameter int TAPS = 64,
	parameter int PW   = 6
) (
	input  wire logic [PW-1:0]   pos_i,
	output logic      [TAPS-1:0] tap_sel_o
);

	always_comb begin
		tap_sel_o = '0;
		tap_sel_o[pos_i] = 1'b1;
	end

endmodule : tap_decode

// >>> sim/pot_checker.sv
// Port checks for the quad wiper controller.
`timescale 1ns/1ps
module pot_checker #(
	parameter int CHANNELS = 4,
	parameter int TAPS     = 64,
	parameter int PW       = 6
) (
	input wire logic                           sys_clk_i,
	input wire logic                           rst_i,
	input wire logic                           scl_i,
	input wire logic                           sda_i,
	input wire logic                           sda_o,
	input wire logic                           sda_oe_n_o,
	input wire logic [CHANNELS-1:0][PW-1:0]    wiper_position_o,
	input wire logic [CHANNELS-1:0][TAPS-1:0]  tap_sel_o
);
	logic [3:0] cnt_q;
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	// Recall moves wipers with the bus idle, so the wiper-bus check waits it out.
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_q <= 4'h0;
		end else if (cnt_q != 4'h8) begin
			cnt_q <= cnt_q + 4'h1;
		end
	end
	property p_sda_zero;
		!sda_o && (sda_oe_n_o || !sda_i);
	endproperty
	a_sda_zero: assert property (p_sda_zero) else $error("sda driven high");
	property p_onehot;
		$onehot(tap_sel_o[0]) && $onehot(tap_sel_o[1]) && $onehot(tap_sel_o[2])
			&& $onehot(tap_sel_o[3]);
	endproperty
	a_onehot: assert property (p_onehot) else $error("tap not one-hot");
	property p_tap_match;
		tap_sel_o[0][wiper_position_o[0]] && tap_sel_o[3][wiper_position_o[3]];
	endproperty
	a_tap_match: assert property (p_tap_match) else $error("tap off wiper");
	property p_wiper_bus;
		cnt_q == 4'h8 && $changed(wiper_position_o) |-> !$past(scl_i);
	endproperty
	a_wiper_bus: assert property (p_wiper_bus) else $error("wiper off bus");
	property p_oe_scl;
		$changed(sda_oe_n_o) |-> !$past(scl_i);
	endproperty
	a_oe_scl: assert property (p_oe_scl) else $error("sda moved, scl high");
	property p_one_ch;
		$changed(wiper_position_o[0]) |-> $stable(wiper_position_o[1])
			&& $stable(wiper_position_o[2]) && $stable(wiper_position_o[3]);
	endproperty
	a_one_ch: assert property (p_one_ch) else $error("channels coupled");
	property p_quiet;
		$fell(rst_i) |-> sda_oe_n_o [*6];
	endproperty
	a_quiet: assert property (p_quiet) else $error("sda pulled in recall");
	property p_oe_hold;
		$fell(sda_oe_n_o) |-> !sda_oe_n_o [*4];
	endproperty
	a_oe_hold: assert property (p_oe_hold) else $error("sda pull too short");
endmodule : pot_checker

// >>> sim/bus_master.sv
// Behavioural two-wire bus master.
`timescale 1ns/1ps
module bus_master (
	input  wire logic sys_clk_i,
	input  wire logic sda_i,
	output logic      scl_o,
	output logic      sda_o
);
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	task automatic hold;
		repeat (4) @(negedge sys_clk_i);
	endtask : hold
	// The master alone makes the clock; it stays high between frames.
	task automatic bit_io(input logic b, output logic s);
		sda_o = b;
		hold();
		scl_o = 1'b1;
		hold();
		s = sda_i;
		scl_o = 1'b0;
		hold();
	endtask : bit_io
	task automatic start;
		sda_o = 1'b1;
		hold();
		scl_o = 1'b1;
		hold();
		sda_o = 1'b0;
		hold();
		scl_o = 1'b0;
		hold();
	endtask : start
	task automatic stop;
		sda_o = 1'b0;
		hold();
		scl_o = 1'b1;
		hold();
		sda_o = 1'b1;
		hold();
	endtask : stop
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], s);
		end
		bit_io(1'b1, s);
		ack = !s;
	endtask : wbyte
	task automatic rbyte(input logic mack, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, d[i]);
		end
		bit_io(!mack, s);
	endtask : rbyte
endmodule : bus_master

// >>> sim/testbench.sv
// Self-checking bench for the quad wiper controller.
`timescale 1ns/1ps
`include "pot_defs.svh"
module testbench;
	import pot_pkg::*;
	logic             sys_clk = 1'b0;
	logic             rst = 1'b1;
	logic [3:0]       pins = 4'ha;
	logic             wg_n = 1'b1;
	wire              scl, m_sda, d_sda, oe_n;
	wire              sda = m_sda & (oe_n | d_sda);
	logic [3:0][5:0]  wip;
	logic [3:0][63:0] taps;
	int               fail_count = 0;
	int               n_checks = 0;
	logic             ack_adr, ack_ins, ack_dat;
	always #20 sys_clk = ~sys_clk;
	bus_master m (.sys_clk_i(sys_clk), .sda_i(sda), .scl_o(scl), .sda_o(m_sda));
	quad_pot_i2c_wiper_control uut (
		.sys_clk_i(sys_clk), .rst_i(rst), .scl_i(scl), .sda_i(sda), .sda_o(d_sda),
		.sda_oe_n_o(oe_n), .addr_pin_bit0_i(pins[0]), .addr_pin_bit1_i(pins[1]),
		.addr_pin_bit2_i(pins[2]), .addr_pin_bit3_i(pins[3]),
		.write_guard_n_i(wg_n), .wiper_position_o(wip), .tap_sel_o(taps)
	);
	task automatic chk(input string s, input logic [63:0] e, input logic [63:0] g);
		n_checks++;
		if (g !== e) begin
			$display("ERROR %s expected %h seen %h", s, e, g);
			fail_count++;
		end
	endtask : chk
	function automatic logic [7:0] ad(input logic [3:0] p);
		return {`POT_ADDR_PREFIX, p, 1'b0};
	endfunction : ad
	task automatic wr(input logic [7:0] a, input logic [3:0] op, input logic [1:0] sl,
			input logic [1:0] ch, input logic [7:0] d, input bit wd);
		m.start();
		m.wbyte(a, ack_adr);
		m.wbyte({op, sl, ch}, ack_ins);
		if (wd) begin
			m.wbyte(d, ack_dat);
		end
		m.stop();
	endtask : wr
	// The byte is fetched twice: a master ACK must get the same byte again.
	task automatic rd(input string s, input logic [3:0] op, input logic [1:0] sl,
			input logic [1:0] ch, input logic [7:0] e);
		logic [7:0] d1, d2;
		m.start();
		m.wbyte(ad(pins), ack_adr);
		m.wbyte({op, sl, ch}, ack_ins);
		m.rbyte(1'b1, d1);
		m.rbyte(1'b0, d2);
		m.stop();
		chk(s, e, d1);
		chk(s, e, d2);
	endtask : rd
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : print_verdict
	initial begin
		repeat (12) @(negedge sys_clk);
		rst = 1'b0;
		repeat (8) @(negedge sys_clk);
		for (int k = 0; k < 4; k++) begin
			chk("recall", 8'h20, wip[k]);
			chk("tap", 64'h1 << 32, taps[k]);
		end
		$display("test recall done");
		wr(ad(pins), `POT_OP_WR_WIPER, 2'h0, 2'h1, 8'h15, 1'b1);
		chk("acks", 3'h7, {ack_adr, ack_ins, ack_dat});
		chk("wiper1", 8'h15, wip[1]);
		chk("wiper0", 8'h20, wip[0]);
		chk("tap1", 64'h1 << 21, taps[1]);
		rd("rd wiper", `POT_OP_RD_WIPER, 2'h0, 2'h1, 8'h15);
		$display("test wiper done");
		wg_n = 1'b0;
		wr(ad(pins), `POT_OP_WR_NV, 2'h3, 2'h2, 8'h07, 1'b1);
		chk("nv nack", 3'h6, {ack_adr, ack_ins, ack_dat});
		wr(ad(pins), `POT_OP_WIP_TO_NV, 2'h3, 2'h1, 8'h00, 1'b0);
		chk("xfer nack", 1'b0, ack_ins);
		rd("xfer kept", `POT_OP_RD_NV, 2'h3, 2'h1, 8'h20);
		rd("nv kept", `POT_OP_RD_NV, 2'h3, 2'h2, 8'h20);
		wr(ad(pins), `POT_OP_WR_WIPER, 2'h0, 2'h3, 8'h3f, 1'b1);
		chk("wiper3", 8'h3f, wip[3]);
		wg_n = 1'b1;
		wr(ad(pins), `POT_OP_WR_NV, 2'h3, 2'h2, 8'h07, 1'b1);
		chk("nv acks", 3'h7, {ack_adr, ack_ins, ack_dat});
		rd("rd nv", `POT_OP_RD_NV, 2'h3, 2'h2, 8'h07);
		wr(ad(pins), `POT_OP_NV_TO_WIP, 2'h3, 2'h2, 8'h00, 1'b0);
		chk("recall op", 8'h07, wip[2]);
		wr(ad(pins), `POT_OP_WIP_TO_NV, 2'h1, 2'h1, 8'h00, 1'b0);
		rd("save op", `POT_OP_RD_NV, 2'h1, 2'h1, 8'h15);
		$display("test guard done");
		wr(ad(pins ^ 4'h1), `POT_OP_WR_WIPER, 2'h0, 2'h0, 8'h2a, 1'b1);
		chk("no ack", 1'b0, ack_adr);
		chk("wiper0 kept", 8'h20, wip[0]);
		pins = 4'h5;
		wr(ad(4'h5), `POT_OP_WR_WIPER, 2'h0, 2'h0, 8'h2a, 1'b1);
		chk("pins ack", 1'b1, ack_adr);
		chk("wiper0 new", 8'h2a, wip[0]);
		wr(ad(pins) | 8'h01, `POT_OP_WR_WIPER, 2'h0, 2'h0, 8'h01, 1'b1);
		chk("rw nack", 3'h0, {ack_adr, ack_ins, ack_dat});
		wr(ad(pins), 4'h3, 2'h0, 2'h0, 8'h01, 1'b1);
		chk("op nack", 3'h4, {ack_adr, ack_ins, ack_dat});
		chk("wiper0 same", 8'h2a, wip[0]);
		$display("test address done");
		wr(ad(pins), `POT_OP_WR_NV, 2'h0, 2'h0, 8'h11, 1'b1);
		rst = 1'b1;
		repeat (3) @(negedge sys_clk);
		rst = 1'b0;
		repeat (8) @(negedge sys_clk);
		chk("re-recall0", 8'h11, wip[0]);
		chk("re-recall2", 8'h20, wip[2]);
		$display("test reset done");
		print_verdict();
	end
	initial begin
		#2000000;
		fail_count++;
		print_verdict();
	end
endmodule : testbench
bind quad_pot_i2c_wiper_control pot_checker #(.CHANNELS(CHANNELS), .TAPS(TAPS), .PW(PW)) chk_i (
	.sys_clk_i(sys_clk_i), .rst_i(rst_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
	.sda_oe_n_o(sda_oe_n_o), .wiper_position_o(wiper_position_o), .tap_sel_o(tap_sel_o)
);
